// >>> common/l21_pkg.sv
// Purpose: Shared constants and types for the line 21 interrupt and host-status block
// Assumes: System clock of 10 MHz; serial link clocked by the host
// Notes:   Request bit positions match the mask data byte layout

package l21_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_FREQ_HZ  = 10_000_000;
  localparam int unsigned PROC_TIME_NS = 2_000;
  localparam int unsigned PROC_CYCLES  =
    (PROC_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BUSY_W       = 5;
  localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(PROC_CYCLES);
  localparam logic [BUSY_W-1:0] BUSY_LAST = BUSY_W'(1);

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [7:0] CMD_NOP     = 8'h00;
  localparam logic [7:0] CMD_MASK_WR = 8'hC7;
  localparam logic [7:0] CMD_RESET   = 8'hFB;
  localparam logic [7:0] CMD_REQ_RD  = 8'h87;

  // ==========================================================================
  // Request / mask layout
  // ==========================================================================
  localparam int unsigned REQ_LINE21    = 1;
  localparam int unsigned REQ_FIELD_END = 2;
  localparam int unsigned REQ_SYNC      = 3;
  localparam int unsigned REQ_CAPTION   = 4;
  localparam int unsigned REQ_EXT       = 5;
  localparam logic [7:0]  REQ_USED      = 8'h3E;
  localparam logic [7:0]  REQ_FIELD_CLR = 8'h06;
  localparam logic [7:0]  REQ_ALL       = 8'hFF;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  REQ_RESET     = 8'h00;
  localparam logic [1:0]  READ_HOLD     = 2'h2;

  // ==========================================================================
  // Status byte layout
  // ==========================================================================
  localparam int unsigned ST_READY = 7;
  localparam int unsigned ST_IRQ   = 3;
  localparam int unsigned ST_FIELD = 1;
  localparam int unsigned ST_LOCK  = 0;

  // ==========================================================================
  // Serial framing
  // ==========================================================================
  localparam logic [6:0] I2C_ADDR      = 7'h14;
  localparam logic [3:0] CNT_DATA_LAST = 4'h7;
  localparam logic [3:0] CNT_ACK       = 4'h8;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic line21_data_event;
    logic field_end_event;
    logic sync_state_change_event;
    logic caption_text_change_event;
    logic extended_service_event;
  } event_t;

  typedef struct packed {
    logic field_one_flag;
    logic video_lock;
  } video_status_t;

  typedef enum logic [0:0] {CMD_IDLE, CMD_BUSY} cmd_state_t;

  typedef struct packed {
    logic [7:0]        mask;
    logic [7:0]        req;
    logic [7:0]        snap;
    logic [7:0]        tx_byte;
    logic [BUSY_W-1:0] busy;
    cmd_state_t        state;
    logic              expect_data;
    logic [1:0]        read_hold;
    logic              tog_prev;
    logic              irq;
    logic              reset_pulse;
  } sys_state_t;

  typedef struct packed {
    logic       rx_toggle;
    logic [7:0] rx_byte;
  } link_keep_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [6:0] shift;
    logic [7:0] tx_cur;
    logic       addr_phase;
    logic       selected;
    logic       reading;
    logic       ack_due;
  } link_frame_t;

endpackage

// >>> rtl/cdc_sync_bits.sv
// Purpose: Two-flop level synchroniser for independent bits
// Assumes: Each bit is a level; bits need not be coherent with each other
// Notes:   First stage feeds only the second stage

`timescale 1ns/1ps

module cdc_sync_bits
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] hold;
  } sync_t;

  sync_t s;
  sync_t next_s;

  // ==========================================================================
  // Chain
  // ==========================================================================
  // Meta stage only ever feeds the hold stage
  always_comb
  begin
    next_s.meta = d_i;
    next_s.hold = s.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign q_o = s.hold;

endmodule

// >>> rtl/line21_interrupt_status.sv
// Purpose: Interrupt requests, mask, status byte and serial slave port of a line 21 decoder
// Assumes: Events and video flags come from the decoder datapath on clk_i;
//          link pins are synchronous to link_clk_i, which only runs inside frames
// Notes:   Returned bytes reflect state as seen at the previous link edges

`timescale 1ns/1ps

// Operation
// (RULE_01) Mask all zero keeps the interrupt output low whatever events occur.
// (RULE_02) Any pending event with its mask bit set drives the interrupt output high.
// (RULE_03) Vertical sync pin carries the interrupt only when sync source is internal.
// (RULE_04) Pending interrupt state is mirrored into bit 3 of the status byte.
// (RULE_05) Each event sets its own request bit; host reads them back.
// (RULE_06) Line 21 data and field end requests clear at end of field. Here the field end request stays set, as its event sets it.
// (RULE_07) Command C7 then a data byte writes the mask; 02,08,10,20 select events.
// (RULE_08) Serial port works as either I2C or SPI with one command set.
// (RULE_09) Device is always slave; master supplies clock and all input data.
// (RULE_10) SPI returns the status byte during every command byte, e.g. 83h.
// (RULE_11) Status field flag means field one; lock flag means video lock.
// (RULE_12) Command 00h changes nothing and only returns status.
// (RULE_13) Without ready polling, SPI master resets with FBh then 00h.
// (RULE_14) Master checks ready before each command byte, polling while zero.
// (RULE_15) Interrupt output drops once no masked request remains pending.
module line21_interrupt_status
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   link_clk_i,
  input  wire logic                   frame_n_i,
  input  wire logic                   serial_spi_mode_i,
  input  wire logic                   sdi_i,
  output logic                        sdo_o,
  output logic                        sdo_oe_n_o,
  input  wire l21_pkg::event_t        events_i,
  input  wire l21_pkg::video_status_t video_i,
  input  wire logic                   vertical_sync_source_i,
  output logic                        irq_output_o,
  output logic                        vsync_irq_pin_o,
  output logic                        vsync_irq_pin_oe_n_o,
  output logic [7:0]                  irq_mask_o,
  output logic                        decoder_reset_o
);

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Event strobes onto their request bit positions
  function automatic logic [7:0] req_set(input l21_pkg::event_t e);
    logic [7:0] r;
    r = '0;
    r[l21_pkg::REQ_LINE21]    = e.line21_data_event;
    r[l21_pkg::REQ_FIELD_END] = e.field_end_event;
    r[l21_pkg::REQ_SYNC]      = e.sync_state_change_event;
    r[l21_pkg::REQ_CAPTION]   = e.caption_text_change_event;
    r[l21_pkg::REQ_EXT]       = e.extended_service_event;
    return r;
  endfunction

  // Status byte assembly
  function automatic logic [7:0] status_byte(input logic                   rdy,
                                             input logic                   irq,
                                             input l21_pkg::video_status_t v);
    logic [7:0] b;
    b = '0;
    b[l21_pkg::ST_READY] = rdy;
    b[l21_pkg::ST_IRQ]   = irq;
    b[l21_pkg::ST_FIELD] = v.field_one_flag;
    b[l21_pkg::ST_LOCK]  = v.video_lock;
    return b;
  endfunction

  // Bit presented for the given count; first bit comes straight from the chain
  function automatic logic tx_bit(input logic [3:0] cnt,
                                  input logic [7:0] first_src,
                                  input logic [7:0] cur);
    logic [2:0] idx;
    idx = 3'(~cnt[2:0]);
    if (cnt == 4'h0)
      return first_src[7];
    else if (cnt > l21_pkg::CNT_DATA_LAST)
      return 1'b1;
    else
      return cur[idx];
  endfunction

  // ==========================================================================
  // Declarations
  // ==========================================================================
  l21_pkg::sys_state_t  s;
  l21_pkg::sys_state_t  next_s;
  l21_pkg::link_keep_t  k;
  l21_pkg::link_keep_t  next_k;
  l21_pkg::link_frame_t f;
  l21_pkg::link_frame_t next_f;
  logic                 tog_q;
  logic [7:0]           tx_sync;
  logic                 spi_q;
  logic                 frame_rst_n;
  logic                 sda_low;

  // ==========================================================================
  // Crossings
  // ==========================================================================
  // Byte-arrival toggle into the system domain
  cdc_sync_bits #(.WIDTH(1)) u_tog_sync
  (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (k.rx_toggle),
    .q_o     (tog_q)
  );

  // Status flags are independent levels, so per-bit sync is safe
  cdc_sync_bits #(.WIDTH(8)) u_tx_sync
  (
    .clk_i   (link_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (s.tx_byte),
    .q_o     (tx_sync)
  );

  // Port mode strap seen by the link logic
  cdc_sync_bits #(.WIDTH(1)) u_mode_sync
  (
    .clk_i   (link_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     (serial_spi_mode_i),
    .q_o     (spi_q)
  );

  // ==========================================================================
  // System domain: requests, mask, command decode
  // ==========================================================================
  always_comb
  begin
    logic [7:0] clr;
    logic       new_byte;
    clr      = '0;
    new_byte = tog_q ^ s.tog_prev;
    next_s   = s;
    next_s.tog_prev    = tog_q;
    next_s.reset_pulse = 1'b0;

    // Field end retires the line 21 data request; the field end request is set again by the same event
    if (events_i.field_end_event)
      clr = clr | l21_pkg::REQ_FIELD_CLR; // RULE_06

    // Byte word is stable: the link only rewrites it after ready returns
    case (s.state)
      l21_pkg::CMD_IDLE:
      begin
        if (new_byte)
        begin
          next_s.state = l21_pkg::CMD_BUSY; // RULE_14
          next_s.busy  = l21_pkg::BUSY_LOAD;
          if (s.read_hold != 2'h0)
            next_s.read_hold = s.read_hold - 2'h1;
          if (s.expect_data)
          begin
            next_s.mask        = k.rx_byte & l21_pkg::REQ_USED; // RULE_07
            next_s.expect_data = 1'b0;
          end
          else
          begin
            case (k.rx_byte)
              l21_pkg::CMD_MASK_WR:
                next_s.expect_data = 1'b1; // RULE_07
              l21_pkg::CMD_REQ_RD:
              begin
                // Snapshot then clear; same-cycle events still land
                next_s.snap      = s.req; // RULE_05
                next_s.read_hold = l21_pkg::READ_HOLD;
                clr              = clr | s.req;
              end
              l21_pkg::CMD_RESET:
              begin
                next_s.mask        = l21_pkg::MASK_RESET; // RULE_13
                next_s.read_hold   = 2'h0;
                next_s.reset_pulse = 1'b1;
                clr                = l21_pkg::REQ_ALL;
              end
              l21_pkg::CMD_NOP:
                next_s.expect_data = 1'b0; // RULE_12
              default:
                next_s.expect_data = 1'b0;
            endcase
          end
        end
      end
      l21_pkg::CMD_BUSY:
      begin
        next_s.busy = s.busy - l21_pkg::BUSY_LAST;
        if (s.busy == l21_pkg::BUSY_LAST)
          next_s.state = l21_pkg::CMD_IDLE;
      end
      default:
        next_s.state = l21_pkg::CMD_IDLE;
    endcase

    // Set wins over any clear in the same cycle
    next_s.req = ((s.req & ~clr) | req_set(events_i)) & l21_pkg::REQ_USED; // RULE_05
    next_s.irq = |(next_s.req & next_s.mask); // RULE_01 RULE_02 RULE_15

    // Readback holds for two bytes to cover the link-side sampling lag
    if (next_s.read_hold != 2'h0)
      next_s.tx_byte = next_s.snap;
    else
      next_s.tx_byte = status_byte(next_s.state == l21_pkg::CMD_IDLE,
                                   next_s.irq, video_i); // RULE_04 RULE_11
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s             <= '0;
      s.mask        <= l21_pkg::MASK_RESET;
      s.req         <= l21_pkg::REQ_RESET;
      s.state       <= l21_pkg::CMD_IDLE;
      s.tx_byte[l21_pkg::ST_READY] <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Pin drives only when the sync source is internal
  assign irq_output_o         = s.irq;
  assign vsync_irq_pin_o      = s.irq;
  assign vsync_irq_pin_oe_n_o = ~vertical_sync_source_i; // RULE_03
  assign irq_mask_o           = s.mask;
  assign decoder_reset_o      = s.reset_pulse;

  // ==========================================================================
  // Link domain: byte framing for both port modes
  // ==========================================================================
  // Frame-local state restarts whenever the master closes the frame
  assign frame_rst_n = rst_n_i & ~frame_n_i;

  always_comb
  begin
    logic [7:0] full;
    full   = {f.shift, sdi_i};
    next_k = k;
    next_f = f;

    // Sample on every rising link edge; the master owns the clock
    if (f.cnt <= l21_pkg::CNT_DATA_LAST)
      next_f.shift = full[6:0]; // RULE_09
    if (f.cnt == 4'h0)
      next_f.tx_cur = tx_sync;

    if (f.cnt == l21_pkg::CNT_DATA_LAST)
    begin
      next_f.ack_due = 1'b0;
      if (spi_q)
      begin
        next_f.cnt     = 4'h0;
        next_k.rx_byte = full; // RULE_08
        next_k.rx_toggle = ~k.rx_toggle;
      end
      else
      begin
        next_f.cnt = l21_pkg::CNT_ACK;
        if (f.addr_phase)
        begin
          next_f.addr_phase = 1'b0;
          next_f.selected   = (full[7:1] == l21_pkg::I2C_ADDR); // RULE_08
          next_f.reading    = full[0];
          next_f.ack_due    = (full[7:1] == l21_pkg::I2C_ADDR);
        end
        else if (f.selected && !f.reading)
        begin
          next_k.rx_byte   = full;
          next_k.rx_toggle = ~k.rx_toggle;
          next_f.ack_due   = 1'b1;
        end
      end
    end
    else if (f.cnt == l21_pkg::CNT_ACK)
    begin
      next_f.cnt     = 4'h0;
      next_f.ack_due = 1'b0;
      // Master not-acknowledge ends a read
      if (f.reading && sdi_i)
        next_f.selected = 1'b0;
    end
    else
      next_f.cnt = f.cnt + 4'h1;
  end

  // Byte word and toggle survive frame ends
  always_ff @(posedge link_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      k <= '0;
    else
      k <= next_k;
  end

  always_ff @(posedge link_clk_i or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      f            <= '0;
      f.addr_phase <= 1'b1;
    end
    else
      f <= next_f;
  end

  // Open-drain data changes on the falling edge, away from start/stop
  always_ff @(negedge link_clk_i or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      sda_low <= 1'b0;
    else if (spi_q)
      sda_low <= 1'b0;
    else if (f.cnt == l21_pkg::CNT_ACK)
      sda_low <= f.ack_due;
    else
      sda_low <= f.selected & f.reading & ~tx_bit(f.cnt, tx_sync, f.tx_cur);
  end

  // SPI output shows the status byte while the command shifts in
  assign sdo_o      = spi_q ? tx_bit(f.cnt, tx_sync, f.tx_cur) : 1'b0; // RULE_10
  assign sdo_oe_n_o = spi_q ? frame_n_i : ~sda_low;

endmodule

// >>> testbench/l21_irq_chk.sv
// Purpose: Port-level assertions for the line 21 interrupt block
// Assumes: One clk_i domain, rst_n_i async active low
// Notes:   Bound to the block; sees its ports only
`timescale 1ns/1ps
module l21_irq_chk
(
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   frame_n_i,
  input wire logic                   serial_spi_mode_i,
  input wire logic                   sdo_oe_n_o,
  input wire l21_pkg::event_t        events_i,
  input wire logic                   vertical_sync_source_i,
  input wire logic                   irq_output_o,
  input wire logic                   vsync_irq_pin_o,
  input wire logic                   vsync_irq_pin_oe_n_o,
  input wire logic [7:0]             irq_mask_o,
  input wire logic                   decoder_reset_o
);
  // ==========================================================
  // Events in mask layout
  logic [7:0] ev_bits;
  assign ev_bits = {2'h0, events_i.extended_service_event, events_i.caption_text_change_event,
                    events_i.sync_state_change_event, events_i.field_end_event,
                    events_i.line21_data_event, 1'h0};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Properties
  property p_quiet; irq_mask_o == 8'h00 |-> !irq_output_o; endproperty
  a_quiet: assert property (p_quiet)
    else $error("interrupt with empty mask");
  property p_raise; |(ev_bits & irq_mask_o) |=> irq_output_o; endproperty
  a_raise: assert property (p_raise)
    else $error("enabled event did not raise interrupt");
  property p_cause; $rose(irq_output_o) |-> $past(|ev_bits) || $changed(irq_mask_o); endproperty
  a_cause: assert property (p_cause)
    else $error("interrupt rose without cause");
  property p_pin; vsync_irq_pin_o == irq_output_o; endproperty
  a_pin: assert property (p_pin)
    else $error("sync pin differs from interrupt");
  property p_pin_oe; vsync_irq_pin_oe_n_o == !vertical_sync_source_i; endproperty
  a_pin_oe: assert property (p_pin_oe)
    else $error("sync pin enable wrong");
  property p_layout; (irq_mask_o & 8'hC1) == 8'h00; endproperty
  a_layout: assert property (p_layout)
    else $error("unused mask bit set");
  property p_pulse; decoder_reset_o |=> !decoder_reset_o; endproperty
  a_pulse: assert property (p_pulse)
    else $error("reset pulse too long");
  property p_idle; frame_n_i |-> sdo_oe_n_o; endproperty
  a_idle: assert property (p_idle)
    else $error("slave drives while deselected");
  property p_spi; serial_spi_mode_i && !frame_n_i && $past(!frame_n_i) |-> !sdo_oe_n_o; endproperty
  a_spi: assert property (p_spi)
    else $error("spi output not enabled in frame");
endmodule
bind line21_interrupt_status l21_irq_chk l21_irq_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .frame_n_i(frame_n_i), .serial_spi_mode_i(serial_spi_mode_i), .sdo_oe_n_o(sdo_oe_n_o),
  .events_i(events_i), .vertical_sync_source_i(vertical_sync_source_i), .irq_output_o(irq_output_o),
  .vsync_irq_pin_o(vsync_irq_pin_o), .vsync_irq_pin_oe_n_o(vsync_irq_pin_oe_n_o),
  .irq_mask_o(irq_mask_o), .decoder_reset_o(decoder_reset_o));

// >>> testbench/spi_host_model.sv
// Purpose: Host processor as SPI master, mode 0, MSB first
// Assumes: Link clock of 30 ns runs only inside a frame
// Notes:   Stands off past the busy window instead of chasing ready;
//          also plays a write-only I2C master on the same pins
`timescale 1ns/1ps
module spi_host_model
(
  output logic      link_clk_o,
  output logic      frame_n_o,
  output logic      sdi_o,
  input  wire logic sdo_i,
  input  wire logic sda_oe_n_i
);
  initial
  begin
    link_clk_o = 1'h0;
    frame_n_o  = 1'h1;
    sdi_o      = 1'h0;
  end
  // ==========================================================
  // One byte exchange; master makes clock and data
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    frame_n_o = 1'h0;
    sdi_o     = tx[7];
    #15;
    for (int i = 7; i >= 0; i--)
    begin
      rx[i]      = sdo_i;
      link_clk_o = 1'h1;
      #15;
      link_clk_o = 1'h0;
      if (i > 0)
        sdi_o = tx[i-1];
      #15;
    end
    frame_n_o = 1'h1;
    sdi_o     = ~tx[0]; // Released line shows no stale bit
  endtask
  // ==========================================================
  // I2C byte plus ack clock; SDA released high for the ack
  task automatic i2c_byte(input logic [7:0] tx, output logic ack_n);
    for (int i = 8; i >= 0; i--)
    begin
      sdi_o = (i > 0) ? tx[i-1] : 1'h1;
      #15;
      if (i == 0)
        ack_n = sda_oe_n_i;
      link_clk_o = 1'h1;
      #15;
      link_clk_o = 1'h0;
    end
  endtask
  // One write frame: our address then one byte; acks returned
  task automatic i2c_cmd(input logic [7:0] b, output logic [1:0] acks);
    frame_n_o = 1'h0;
    i2c_byte({l21_pkg::I2C_ADDR, 1'h0}, acks[1]);
    i2c_byte(b, acks[0]);
    frame_n_o = 1'h1;
    sdi_o     = 1'h1; // Pull-up level once released
  endtask
  // ==========================================================
  // Wait out busy plus sync before the next byte
  task automatic stand_off();
    #3000;
  endtask
endmodule

// >>> testbench/line21_interrupt_status_tb.sv
// Purpose: Self-checking bench for the line 21 interrupt block
// Assumes: SPI strap high until the closing I2C scenario; host model drives the link
// Notes:   Status byte is read on the second of two no-ops
`timescale 1ns/1ps
module line21_interrupt_status_tb;
  logic                   clk_i, rst_n_i, link_clk, frame_n, sdi, sdo, sdo_oe_n;
  logic                   vsrc, irq, vpin, vpin_oe_n, dec_rst, spi_mode;
  logic [7:0]             mask, rx;
  l21_pkg::event_t        events;
  l21_pkg::video_status_t video;
  int                     num_errors, total_checks, resets_seen;
  initial
  begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
    if (dec_rst === 1'h1)
      resets_seen++;
  line21_interrupt_status line21_interrupt_status_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link_clk_i(link_clk), .frame_n_i(frame_n), .serial_spi_mode_i(spi_mode), .sdi_i(sdi), .sdo_o(sdo),
    .sdo_oe_n_o(sdo_oe_n), .events_i(events), .video_i(video), .vertical_sync_source_i(vsrc),
    .irq_output_o(irq), .vsync_irq_pin_o(vpin), .vsync_irq_pin_oe_n_o(vpin_oe_n),
    .irq_mask_o(mask), .decoder_reset_o(dec_rst));
  spi_host_model spi_host_model_inst (.link_clk_o(link_clk), .frame_n_o(frame_n), .sdi_o(sdi), .sdo_i(sdo),
    .sda_oe_n_i(sdo_oe_n));
  // ==========================================================
  // Helpers
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] b);
    spi_host_model_inst.xfer(b, rx);
    spi_host_model_inst.stand_off();
  endtask
  task automatic status_read();
    send(l21_pkg::CMD_NOP);
    send(l21_pkg::CMD_NOP);
  endtask
  task automatic set_mask(input logic [7:0] m);
    send(l21_pkg::CMD_MASK_WR);
    send(m);
    check8(mask, m & 8'h3E, "mask");
  endtask
  task automatic read_reqs(input logic [7:0] exp);
    send(l21_pkg::CMD_REQ_RD);
    status_read();
    check8(rx, exp, "requests");
  endtask
  task automatic pulse(input l21_pkg::event_t e);
    @(posedge clk_i);
    events <= e;
    @(posedge clk_i);
    events <= '0;
    @(negedge clk_i);
  endtask
  function automatic l21_pkg::event_t ev_of(input logic [7:0] c);
    return {c[1], c[2], c[3], c[4], c[5]};
  endfunction
  // ==========================================================
  // Scenarios
  task automatic t_status();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      video <= i[1:0];
      status_read();
      check8(rx, 8'h80 | 8'(i), "status");
      check8(mask, 8'h00, "nop kept mask");
    end
    // Later scenarios expect field and lock clear in the status byte
    @(posedge clk_i);
    video <= '0;
  endtask
  task automatic t_codes();
    logic [7:0] codes [4] = '{8'h02, 8'h08, 8'h10, 8'h20};
    foreach (codes[k])
    begin
      set_mask(codes[k]);
      pulse(ev_of(codes[k]));
      check8({7'h00, irq}, 8'h01, "irq up");
      check8({7'h00, vpin}, 8'h01, "pin up");
      status_read();
      check8(rx, 8'h88, "pending bit");
      read_reqs(codes[k]);
      check8({7'h00, irq}, 8'h00, "irq down");
    end
  endtask
  task automatic t_mask_zero();
    set_mask(8'h00);
    pulse(5'h1F);
    repeat (5) @(posedge clk_i);
    check8({7'h00, irq}, 8'h00, "masked irq");
    read_reqs(8'h3E);
  endtask
  task automatic t_field_end();
    set_mask(8'h02);
    pulse(ev_of(8'h02));
    check8({7'h00, irq}, 8'h01, "line21 irq");
    pulse(ev_of(8'h04));
    check8({7'h00, irq}, 8'h00, "cleared at field end");
    read_reqs(8'h04);
    @(posedge clk_i);
    vsrc <= 1'h0;
    @(negedge clk_i);
    check8({7'h00, vpin_oe_n}, 8'h01, "pin released");
    @(posedge clk_i);
    vsrc <= 1'h1;
    @(negedge clk_i);
    check8({7'h00, vpin_oe_n}, 8'h00, "pin driven");
  endtask
  task automatic t_reset();
    set_mask(8'hFF);
    pulse(ev_of(8'h08));
    check8({7'h00, irq}, 8'h01, "irq before reset");
    resets_seen = 0;
    send(l21_pkg::CMD_RESET);
    send(l21_pkg::CMD_NOP);
    check8(8'(resets_seen), 8'h01, "reset pulses");
    check8(mask, 8'h00, "mask after reset");
    check8({7'h00, irq}, 8'h00, "irq after reset");
    read_reqs(8'h00);
  endtask
  // Same mask command over the I2C framing; strap stays low afterwards
  task automatic t_i2c();
    logic [1:0] acks;
    @(posedge clk_i);
    spi_mode <= 1'h0;
    spi_host_model_inst.i2c_cmd(l21_pkg::CMD_MASK_WR, acks);
    spi_host_model_inst.stand_off();
    check8({6'h00, acks}, 8'h00, "i2c address and command acks");
    spi_host_model_inst.i2c_cmd(8'h10, acks);
    spi_host_model_inst.stand_off();
    check8({6'h00, acks}, 8'h00, "i2c data acks");
    check8(mask, 8'h10, "i2c mask");
  endtask
  // ==========================================================
  // Verdict
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, well past the expected run of about 200 us
  initial
  begin
    #1_000_000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end
  initial
  begin
    num_errors   = 0;
    total_checks = 0;
    resets_seen  = 0;
    rst_n_i      = 1'h0;
    events       = '0;
    video        = '0;
    vsrc         = 1'h1;
    spi_mode     = 1'h1;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    t_status();
    t_codes();
    t_mask_zero();
    t_field_end();
    t_reset();
    t_i2c();
    stop_test();
  end
endmodule
